// ### bus_cycle_pkg.sv
package bus_cycle_pkg;

    // ------------------------------------------------------------
    // register byte offsets on the wishbone bus
    // ------------------------------------------------------------
    localparam logic [3:0]  BUS_CONFIG_ONE_OFFSET = 4'h0;
    localparam logic [3:0]  BUS_CONFIG_TWO_OFFSET = 4'h4;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int          MOTOR_TIMER_EN_BIT    = 14;
    localparam int          PULSE_TIMER_EN_BIT    = 13;
    localparam int          SPACE0_SIZE_BIT       = 0;
    localparam int          RW_IDLE_HI_BIT        = 9;
    localparam int          RW_IDLE_LO_BIT        = 8;
    localparam int          CONSEC_IDLE_BIT       = 4;
    localparam int          SELECT_WIDEN_BIT      = 0;

    // ------------------------------------------------------------
    // reset values and writable masks
    // ------------------------------------------------------------
    localparam logic [15:0] BUS_CONFIG_ONE_RESET  = 16'h600F;
    localparam logic [15:0] BUS_CONFIG_ONE_RW     = 16'h6001;
    localparam logic [15:0] BUS_CONFIG_ONE_ONES   = 16'h000E;
    localparam logic [15:0] BUS_CONFIG_TWO_RESET  = 16'hFFFF;
    localparam logic [15:0] BUS_CONFIG_TWO_RW     = 16'h0311;
    localparam logic [15:0] BUS_CONFIG_TWO_ONES   = 16'hFCEE;

    // ------------------------------------------------------------
    // timer block indices and cycle counts
    // ------------------------------------------------------------
    localparam int          MOTOR_TIMER           = 0;
    localparam int          PULSE_TIMER           = 1;
    localparam int          TIMER_COUNT           = 2;
    localparam logic [2:0]  CONSEC_IDLE_CYCLES    = 3'h1;
    localparam logic [1:0]  IDLE_COUNT_MAX        = 2'h3;

    // ------------------------------------------------------------
    // external bus cycle states, gray along idle-th-t1-t2-tf
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_LEAD  = 3'h1,
        ST_T1    = 3'h3,
        ST_T2    = 3'h2,
        ST_TRAIL = 3'h6
    } bus_state_t;

endpackage

// ### pin_sync.sv
`timescale 1ns/100ps
`default_nettype none

// three-stage pin synchroniser; output moves once stages two and three agree
module pin_sync (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // pin and result
    input  wire logic pin_i,
    output var  logic level_o
);

    logic stage1;
    logic stage2;
    logic stage3;

    // ------------------------------------------------------------
    // sampling chain
    // ------------------------------------------------------------
    // stage1 feeds only stage2, so no logic sees a metastable value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage1  <= 1'b0;
            stage2  <= 1'b0;
            stage3  <= 1'b0;
            level_o <= 1'b0;
        end else begin
            stage1 <= pin_i;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                level_o <= stage3;
            end
        end
    end

endmodule

`default_nettype wire

// ### external_bus_cycle_control.sv
// Contract
// R1: software writes all bits of bus_config_one once after power-on reset and never changes them.
// R2: with on-chip rom enabled, software makes no space 0 access before the config registers are set.
// R3: motor_timer_access_enable resets to 1 and when 0 blocks motor timer register access.
// R4: pulse_timer_access_enable resets to 1 and when 0 blocks pulse timer register access.
// R5: reserved bits 15 and 12 to 4 of bus_config_one read 0 and must be written 0.
// R6: reserved bits 3 to 1 of bus_config_one and 15-10, 7-5, 3-1 of bus_config_two read 1.
// R7: with on-chip rom enabled, software clears space0_bus_size to 8 bits before space 0 access.
// R8: with on-chip rom disabled, the space 0 bus size comes from the mode pin, not the register.
// R9: the read-to-write idle field (bits 9:8, reset 11) inserts 0 to 3 idle cycles.
// R10: consecutive_access_idle set inserts one idle cycle with the select negated between accesses.
// R11: a write after a read gets the larger of the read-write and consecutive idle counts.
// R12: select_assert_widen set adds one select-only cycle before and after each bus cycle.
// R13: a plain external access takes exactly two clock states.
// R14: widened cycles assert only the select, and write data holds through the trailing cycle.
// R15: idle cycles already present count toward the read-to-write idle total.
// R16: idle cycles already present satisfy the consecutive-access idle cycle.
// R17: a disabled timer block sees no register strobes, reads give zero and writes do nothing.
//
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module external_bus_cycle_control
    import bus_cycle_pkg::*;
(
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // wishbone register slave
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [3:0]             wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output var  logic [31:0]            wb_dat_o,
    output var  logic                   wb_ack_o,
    // mode pins
    input  wire logic                   rom_enabled_i,
    input  wire logic                   mode_bus_size_i,
    output var  logic                   space0_bus_size_o,
    // internal space 0 access port
    input  wire logic                   ext_req_i,
    input  wire logic                   ext_we_i,
    input  wire logic [17:0]            ext_addr_i,
    input  wire logic [7:0]             ext_wdata_i,
    output var  logic [7:0]             ext_rdata_o,
    output var  logic                   ext_ack_o,
    // external memory pins
    output var  logic [17:0]            ext_address_o,
    output var  logic                   space0_select_n_o,
    output var  logic                   read_strobe_n_o,
    output var  logic                   low_byte_write_strobe_n_o,
    output var  logic [7:0]             ext_data_o,
    output var  logic                   ext_data_oe_o,
    input  wire logic [7:0]             ext_data_i,
    // timer block register strobes, index 0 motor, 1 pulse
    input  wire logic [TIMER_COUNT-1:0] timer_rd_i,
    input  wire logic [TIMER_COUNT-1:0] timer_wr_i,
    input  wire logic [TIMER_COUNT-1:0][15:0] timer_rdata_i,
    output var  logic [TIMER_COUNT-1:0] timer_rd_o,
    output var  logic [TIMER_COUNT-1:0] timer_wr_o,
    output var  logic [TIMER_COUNT-1:0][15:0] timer_rdata_o
);

    logic [15:0]            bus_config_one;
    logic [15:0]            bus_config_two;
    logic                   wb_req;
    logic                   rom_enabled;
    logic                   mode_bus_size;
    logic [TIMER_COUNT-1:0] timer_enable;
    bus_state_t             state;
    bus_state_t             next_state;
    logic                   acc_we;
    logic                   acc_widen;
    logic                   next_we;
    logic                   last_valid;
    logic                   last_read;
    logic [1:0]             idle_cnt;
    logic [2:0]             idle_need;
    logic [2:0]             idle_seen;
    logic                   start_ok;

    // merge a write into a register, honouring byte lanes and writable bits
    function automatic logic [15:0] merge_write(input logic [15:0] old_val,
                                                input logic [15:0] rw_mask,
                                                input logic [1:0]  sel,
                                                input logic [15:0] wdata);
        logic [15:0] lane_mask;
        lane_mask = {{8{sel[1]}}, {8{sel[0]}}} & rw_mask;
        return (old_val & ~lane_mask) | (wdata & lane_mask);
    endfunction
    // true while the state drives the select low
    function automatic logic select_state(input bus_state_t st);
        return st != ST_IDLE;
    endfunction
    // true while the state may drive read or write strobes
    function automatic logic strobe_state(input bus_state_t st);
        return (st == ST_T1) || (st == ST_T2);
    endfunction

    // ------------------------------------------------------------
    // mode pin synchronisers
    // ------------------------------------------------------------
    pin_sync rom_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (rom_enabled_i),
        .level_o (rom_enabled)
    );

    pin_sync size_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (mode_bus_size_i),
        .level_o (mode_bus_size)
    );

    // ------------------------------------------------------------
    // wishbone slave, one wait state, unmapped reads give zero
    // ------------------------------------------------------------
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // ack one cycle after the strobe, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    // reserved bits never change since only the writable mask is merged
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_config_one <= BUS_CONFIG_ONE_RESET;
            bus_config_two <= BUS_CONFIG_TWO_RESET;
        end else if (wb_req && wb_we_i) begin
            if (wb_adr_i == BUS_CONFIG_ONE_OFFSET) begin
                bus_config_one <= merge_write(bus_config_one, BUS_CONFIG_ONE_RW,
                                              wb_sel_i[1:0], wb_dat_i[15:0]); // R5
            end
            if (wb_adr_i == BUS_CONFIG_TWO_OFFSET) begin
                bus_config_two <= merge_write(bus_config_two, BUS_CONFIG_TWO_RW,
                                              wb_sel_i[1:0], wb_dat_i[15:0]); // R6
            end
        end
    end

    // read data, upper half always zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h00000000;
        end else if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
                BUS_CONFIG_ONE_OFFSET: wb_dat_o <= {16'h0000, bus_config_one};
                BUS_CONFIG_TWO_OFFSET: wb_dat_o <= {16'h0000, bus_config_two};
                default:               wb_dat_o <= 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // effective space 0 bus size
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            space0_bus_size_o <= 1'b1;
        end else begin
            space0_bus_size_o <= rom_enabled ? bus_config_one[SPACE0_SIZE_BIT]
                                             : mode_bus_size; // R8
        end
    end

    // ------------------------------------------------------------
    // timer register strobe gating
    // ------------------------------------------------------------
    assign timer_enable[MOTOR_TIMER] = bus_config_one[MOTOR_TIMER_EN_BIT]; // R3
    assign timer_enable[PULSE_TIMER] = bus_config_one[PULSE_TIMER_EN_BIT]; // R4

    // one cycle of latency buys registered outputs toward each timer
    for (genvar t = 0; t < TIMER_COUNT; t++) begin : gen_timer_gate
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                timer_rd_o[t]    <= 1'b0;
                timer_wr_o[t]    <= 1'b0;
                timer_rdata_o[t] <= 16'h0000;
            end else begin
                timer_rd_o[t]    <= timer_rd_i[t] && timer_enable[t]; // R17
                timer_wr_o[t]    <= timer_wr_i[t] && timer_enable[t]; // R17
                timer_rdata_o[t] <= timer_enable[t] ? timer_rdata_i[t] : 16'h0000; // R17
            end
        end
    end

    // ------------------------------------------------------------
    // idle cycle requirement before the next access
    // ------------------------------------------------------------
    // the idle cycle being sampled counts, so idle_seen is one ahead
    always_comb begin
        idle_need = 3'h0;
        if (last_valid && bus_config_two[CONSEC_IDLE_BIT]) begin
            idle_need = CONSEC_IDLE_CYCLES; // R10
        end
        if (last_valid && last_read && ext_we_i &&
            ({1'b0, bus_config_two[RW_IDLE_HI_BIT:RW_IDLE_LO_BIT]} > idle_need)) begin
            idle_need = {1'b0, bus_config_two[RW_IDLE_HI_BIT:RW_IDLE_LO_BIT]}; // R9 R11
        end
        idle_seen = {1'b0, idle_cnt} + 3'h1;
        start_ok  = idle_seen >= idle_need; // R15 R16
    end

    // ------------------------------------------------------------
    // bus cycle state machine
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (ext_req_i && !ext_ack_o && start_ok) begin
                    next_state = bus_config_two[SELECT_WIDEN_BIT] ? ST_LEAD : ST_T1; // R12
                end
            end
            ST_LEAD:  next_state = ST_T1;
            ST_T1:    next_state = ST_T2; // R13
            ST_T2:    next_state = acc_widen ? ST_TRAIL : ST_IDLE; // R12
            ST_TRAIL: next_state = ST_IDLE;
            default:  next_state = ST_IDLE;
        endcase
        next_we = (state == ST_IDLE) ? ext_we_i : acc_we;
    end

    // state and access capture
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state         <= ST_IDLE;
            acc_we        <= 1'b0;
            acc_widen     <= 1'b0;
            ext_address_o <= 18'h00000;
            ext_data_o    <= 8'h00;
        end else begin
            state <= next_state;
            if (state == ST_IDLE && next_state != ST_IDLE) begin
                acc_we        <= ext_we_i;
                acc_widen     <= bus_config_two[SELECT_WIDEN_BIT];
                ext_address_o <= ext_addr_i;
                ext_data_o    <= ext_wdata_i;
            end
        end
    end

    // history of the previous access for idle insertion
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_valid <= 1'b0;
            last_read  <= 1'b0;
            idle_cnt   <= 2'h0;
        end else if (select_state(state)) begin
            last_valid <= 1'b1;
            last_read  <= !acc_we;
            idle_cnt   <= 2'h0;
        end else if (idle_cnt != IDLE_COUNT_MAX) begin
            idle_cnt <= idle_cnt + 2'h1;
        end
    end

    // pins are registered from the next state so they leave clean
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            space0_select_n_o         <= 1'b1;
            read_strobe_n_o           <= 1'b1;
            low_byte_write_strobe_n_o <= 1'b1;
            ext_data_oe_o             <= 1'b0;
        end else begin
            space0_select_n_o         <= !select_state(next_state);
            read_strobe_n_o           <= !(strobe_state(next_state) && !next_we); // R14
            low_byte_write_strobe_n_o <= !(strobe_state(next_state) && next_we); // R14
            ext_data_oe_o             <= next_we && (strobe_state(next_state) ||
                                                     next_state == ST_TRAIL); // R14
        end
    end

    // read data captured at the end of t2, ack pulses once per access
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_rdata_o <= 8'h00;
            ext_ack_o   <= 1'b0;
        end else begin
            if (state == ST_T2 && !acc_we) begin
                ext_rdata_o <= ext_data_i;
            end
            ext_ack_o <= (state == ST_T2 && !acc_widen) || state == ST_TRAIL;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_motor_gate: assert property (timer_rd_o[MOTOR_TIMER] |-> // R3
        $past(bus_config_one[MOTOR_TIMER_EN_BIT]))
        else $error("motor timer strobe while disabled");
    a_pulse_gate: assert property (!$past(bus_config_one[PULSE_TIMER_EN_BIT]) |-> // R4
        !timer_wr_o[PULSE_TIMER] && timer_rdata_o[PULSE_TIMER] == 16'h0000)
        else $error("pulse timer access while disabled");
    a_zero_reserved: assert property ((bus_config_one & 16'h9FF0) == 16'h0000) // R5
        else $error("reserved zero bits changed");
    a_one_reserved: assert property ( // R6
        (bus_config_one & BUS_CONFIG_ONE_ONES) == BUS_CONFIG_ONE_ONES &&
        (bus_config_two & BUS_CONFIG_TWO_ONES) == BUS_CONFIG_TWO_ONES)
        else $error("reserved one bits changed");
    // mode pin sync reads 0 during reset, so the first edge after it is left out
    a_size_source: assert property (!$past(rst_i) && !$past(rom_enabled) |-> // R8
        space0_bus_size_o == $past(mode_bus_size))
        else $error("bus size not from mode pin");
    a_two_states: assert property ($fell(read_strobe_n_o) |=> // R13
        !read_strobe_n_o ##1 read_strobe_n_o)
        else $error("read strobe not two cycles");
    a_widen_lead: assert property ($fell(space0_select_n_o) && acc_widen |-> // R12
        read_strobe_n_o && low_byte_write_strobe_n_o ##1 !space0_select_n_o)
        else $error("lead cycle drives a strobe");
    a_widen_trail: assert property ($rose(low_byte_write_strobe_n_o) && acc_widen |-> // R14
        !space0_select_n_o && ext_data_oe_o ##1 space0_select_n_o)
        else $error("trail cycle wrong");
    a_rw_idle: assert property (state == ST_IDLE && next_state != ST_IDLE && // R9
        last_valid && last_read && ext_we_i |->
        idle_seen >= {1'b0, bus_config_two[RW_IDLE_HI_BIT:RW_IDLE_LO_BIT]})
        else $error("read to write idle too short");
    a_consec_idle: assert property ($rose(space0_select_n_o) && // R10
        bus_config_two[CONSEC_IDLE_BIT] |=> space0_select_n_o)
        else $error("select not negated between accesses");
    a_ack_pulse: assert property (ext_ack_o |=> !ext_ack_o) // R13
        else $error("access ack longer than one cycle");
    c_read_plain:  cover property ($fell(read_strobe_n_o) && !acc_widen);
    c_write_wide:  cover property ($fell(low_byte_write_strobe_n_o) && acc_widen);
    c_rw_wait:     cover property (state == ST_IDLE && ext_req_i && !ext_ack_o && !start_ok);
    c_timer_block: cover property (timer_rd_i[MOTOR_TIMER] && !timer_enable[MOTOR_TIMER]);

endmodule

`default_nettype wire

// ### sram_model.sv
`timescale 1ns/100ps
`default_nettype none

// byte-wide static memory sitting on space 0
module sram_model (
    // clock
    input  wire logic        clk_i,
    // memory pins
    input  wire logic [17:0] addr_i,
    input  wire logic        sel_n_i,
    input  wire logic        rd_n_i,
    input  wire logic        wr_n_i,
    input  wire logic [7:0]  data_i,
    output var  logic [7:0]  data_o
);
    logic [7:0] mem [256];
    logic [7:0] last = 8'h00;

    // store on the write strobe, remember what was last driven
    always_ff @(posedge clk_i) begin
        if (!sel_n_i && !wr_n_i) begin
            mem[addr_i[7:0]] <= data_i;
        end
        if (!sel_n_i && !rd_n_i) begin
            last <= mem[addr_i[7:0]];
        end
    end

    // a released bus shows the inverse, so a late sample never looks right
    assign data_o = (!sel_n_i && !rd_n_i) ? mem[addr_i[7:0]] : ~last;
endmodule

`default_nettype wire

// ### tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb;
    logic              clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic              wb_we_i = 1'b0, rom_enabled_i = 1'b1, mode_bus_size_i = 1'b0;
    logic              ext_req_i = 1'b0, ext_we_i = 1'b0;
    logic [3:0]        wb_adr_i = 4'h0, wb_sel_i = 4'h3;
    logic [31:0]       wb_dat_i = 32'h0, wb_dat_o;
    logic [17:0]       ext_addr_i = 18'h0, ext_address_o;
    logic [7:0]        ext_wdata_i = 8'h00, ext_rdata_o, ext_data_o, ext_data_i, rd;
    logic              wb_ack_o, space0_bus_size_o, ext_ack_o, space0_select_n_o;
    logic              read_strobe_n_o, low_byte_write_strobe_n_o, ext_data_oe_o;
    logic [1:0]        timer_rd_i = 2'h0, timer_wr_i = 2'h0, timer_rd_o, timer_wr_o;
    logic [1:0][15:0]  timer_rdata_i = '0, timer_rdata_o;
    logic [15:0]       q;
    int                mismatches = 0, compares = 0, sel_cnt, stb_cnt, gap, idle = 0, oe_cnt;

    external_bus_cycle_control dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rom_enabled_i,
        .mode_bus_size_i, .space0_bus_size_o, .ext_req_i, .ext_we_i, .ext_addr_i,
        .ext_wdata_i, .ext_rdata_o, .ext_ack_o, .ext_address_o, .space0_select_n_o,
        .read_strobe_n_o, .low_byte_write_strobe_n_o, .ext_data_o, .ext_data_oe_o,
        .ext_data_i, .timer_rd_i, .timer_wr_i, .timer_rdata_i, .timer_rd_o, .timer_wr_o,
        .timer_rdata_o);
    sram_model mem_u (.clk_i, .addr_i(ext_address_o), .sel_n_i(space0_select_n_o),
        .rd_n_i(read_strobe_n_o), .wr_n_i(low_byte_write_strobe_n_o),
        .data_i(ext_data_o), .data_o(ext_data_i));

    // --------------------------------------------------------
    // shared bus cycles and comparison
    // --------------------------------------------------------
    task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one classic cycle; the leading edge keeps cyc low for a cycle
    task wb(input logic we, input logic [3:0] a, input logic [15:0] d, output logic [15:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= {16'h0000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        chk("wb_ack", 16'h0001, {15'h0, wb_ack_o});
        r = wb_dat_o[15:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    // request stays up on return so a following call runs back to back
    task ext_op(input logic we, input logic [17:0] a, input logic [7:0] d);
        int n;
        n = 0;
        sel_cnt = 0;
        stb_cnt = 0;
        oe_cnt = 0;
        gap = 0;
        ext_req_i <= 1'b1;
        ext_we_i <= we;
        ext_addr_i <= a;
        ext_wdata_i <= d;
        do begin
            @(posedge clk_i);
            n++;
            if (space0_select_n_o === 1'b0) begin
                if (sel_cnt == 0) gap = idle;
                sel_cnt++;
                idle = 0;
            end else begin
                idle++;
            end
            if (read_strobe_n_o === 1'b0 || low_byte_write_strobe_n_o === 1'b0) stb_cnt++;
            if (ext_data_oe_o === 1'b1) oe_cnt++;
        end while (ext_ack_o !== 1'b1 && n < 40);
        chk("ext_ack", 16'h0001, {15'h0, ext_ack_o});
        rd = ext_rdata_o;
    endtask

    // --------------------------------------------------------
    // scenarios
    // --------------------------------------------------------
    task t_timers(input logic [1:0] en);
        timer_rd_i <= 2'b11;
        timer_wr_i <= 2'b11;
        timer_rdata_i <= {16'h5678, 16'h1234};
        repeat (2) @(posedge clk_i);
        chk("timer_rd", {14'h0, en}, {14'h0, timer_rd_o});
        chk("timer_wr", {14'h0, en}, {14'h0, timer_wr_o});
        chk("motor_rdata", en[0] ? 16'h1234 : 16'h0000, timer_rdata_o[0]);
        chk("pulse_rdata", en[1] ? 16'h5678 : 16'h0000, timer_rdata_o[1]);
        timer_rd_i <= 2'b00;
        timer_wr_i <= 2'b00;
    endtask

    task t_regs;
        wb(1'b0, 4'h0, 16'h0000, q);
        chk("bus_config_one", 16'h600F, q);
        wb(1'b0, 4'h4, 16'h0000, q);
        chk("bus_config_two", 16'hFFFF, q);
        wb(1'b1, 4'h8, 16'h5A5A, q);
        wb(1'b0, 4'h8, 16'h0000, q);
        chk("unmapped", 16'h0000, q);
        wb(1'b1, 4'h0, 16'h200E, q);
        wb(1'b1, 4'h4, 16'hFFFF, q);
        wb(1'b0, 4'h0, 16'h0000, q);
        chk("bus_config_one", 16'h200E, q);
        chk("space0_bus_size", 16'h0000, {15'h0, space0_bus_size_o});
    endtask

    task t_wide;
        ext_op(1'b1, 18'h00055, 8'hA5);
        chk("wide_select", 16'h0004, sel_cnt[15:0]);
        chk("wide_strobe", 16'h0002, stb_cnt[15:0]);
        chk("wide_oe", 16'h0003, oe_cnt[15:0]);
        ext_op(1'b0, 18'h00055, 8'h00);
        chk("wide_read", 16'h00A5, {8'h00, rd});
        chk("read_oe", 16'h0000, oe_cnt[15:0]);
        chk("consec_gap", 16'h0001, {15'h0, gap >= 1 && gap <= 2});
        ext_req_i <= 1'b0;
    endtask

    // every read-to-write idle code, read then write back to back
    task t_iw;
        int lo;
        int hi;
        for (int iw = 0; iw < 4; iw++) begin
            lo = iw > 1 ? iw : 1;
            hi = iw > 2 ? iw : 2;
            wb(1'b1, 4'h4, {6'h3F, iw[1:0], 8'hEE}, q);
            ext_op(1'b1, {16'h0010, iw[1:0]}, {6'h0F, iw[1:0]});
            chk("plain_oe", 16'h0002, oe_cnt[15:0]);
            ext_op(1'b0, {16'h0010, iw[1:0]}, 8'h00);
            chk("plain_read", {8'h00, 6'h0F, iw[1:0]}, {8'h00, rd});
            chk("plain_select", 16'h0002, sel_cnt[15:0]);
            ext_op(1'b1, {16'h0010, iw[1:0]}, 8'hC3);
            chk("turn_gap", 16'h0001, {15'h0, gap >= lo && gap <= hi});
            ext_req_i <= 1'b0;
        end
    endtask

    // pin size wins over the cleared register bit once rom is off
    task t_mode;
        rom_enabled_i <= 1'b0;
        mode_bus_size_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk("mode_size", 16'h0001, {15'h0, space0_bus_size_o});
    endtask

    task wrap_up;
        if (mismatches == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // clock, main sequence and watchdog
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_timers(2'b11);
        t_regs;
        t_timers(2'b10);
        t_wide;
        t_iw;
        t_mode;
        wrap_up;
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        mismatches++;
        wrap_up;
    end
endmodule

`default_nettype wire
